// File: pkg/pcef_pkg.sv
// Package: register map, field layout and timing constants for event flags
package pcef_pkg;

  // ****************************************************************
  // Register word indices (byte address is index times four)
  // ****************************************************************
  localparam logic [7:0] DET_VIEW_IDX  = 8'h04;
  localparam logic [7:0] DET_RC_IDX    = 8'h05;
  localparam logic [7:0] FLT_VIEW_IDX  = 8'h06;
  localparam logic [7:0] FLT_RC_IDX    = 8'h07;
  localparam logic [7:0] STL_VIEW_IDX  = 8'h08;
  localparam logic [7:0] STL_RC_IDX    = 8'h09;
  localparam logic [7:0] CTRL_IDX      = 8'h10;
  localparam logic [7:0] STAT_IDX      = 8'h11;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;
  localparam logic [7:0] EVT_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_DCHG  = 0;   // detect_change_select
  localparam int CTRL_CCHG  = 1;   // class_change_select
  localparam int CTRL_MODE  = 2;   // two bits, operating mode
  localparam int CTRL_4P    = 4;   // two bits, pair groups as 4-pair ports
  localparam int CTRL_DUAL  = 6;   // two bits, dual signature per port

  // ****************************************************************
  // Timing: 5 ms merge window at 40 MHz
  // ****************************************************************
  localparam int CLK_HZ      = 40000000;
  localparam int MERGE_US    = 5000;
  localparam int MERGE_CYC   = (CLK_HZ / 1000000) * MERGE_US;

  typedef enum logic [1:0] {MODE_MANUAL, MODE_SEMI, MODE_AUTO} pcef_mode_e;

  // Per-channel event strobes from the analog engines
  typedef struct packed {
    logic [3:0] det_done;
    logic [3:0] det_chg;
    logic [3:0] cls_done;
    logic [3:0] cls_chg;
    logic [3:0] disc;
    logic [3:0] ovld;
    logic [3:0] current_limit_fault;
    logic [3:0] startup_fault;
  } pcef_evt_s;

endpackage

// File: hw/pcef_event_flags.sv
// Event flag bank for four channels with plain and clear-on-read views
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module pcef_event_flags (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event strobes from the channel engines, same clock
  input  wire pcef_pkg::pcef_evt_s evt,
  input  wire logic [3:0]  ch_off,
  input  wire logic [3:0]  power_req_pending,
  // Summaries and attention pin
  output logic [3:0]       int_summary,
  output logic             attention_request_n
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       acc;
  logic       rd;
  logic       wr;
  logic [7:0] idx;
  logic       mapped;
  assign acc = psel & penable;
  assign rd  = acc & ~pwrite;
  assign wr  = acc & pwrite;
  assign idx = paddr[9:2];
  assign pready = 1'b1;
  // Unmapped or unaligned access is answered with an error, no effect
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx inside {pcef_pkg::DET_VIEW_IDX, pcef_pkg::DET_RC_IDX,
                               pcef_pkg::FLT_VIEW_IDX, pcef_pkg::FLT_RC_IDX,
                               pcef_pkg::STL_VIEW_IDX, pcef_pkg::STL_RC_IDX,
                               pcef_pkg::CTRL_IDX, pcef_pkg::STAT_IDX});
  assign pslverr = acc & ~mapped;

  logic clr_det;
  logic clr_flt;
  logic clr_stl;
  assign clr_det = rd & mapped & (idx == pcef_pkg::DET_RC_IDX);
  assign clr_flt = rd & mapped & (idx == pcef_pkg::FLT_RC_IDX);
  assign clr_stl = rd & mapped & (idx == pcef_pkg::STL_RC_IDX);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [7:0] ctrl_q;
  // Software writes mode, change selects and port wiring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pcef_pkg::CTRL_RST;
    end else if (wr && mapped && idx == pcef_pkg::CTRL_IDX) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  logic       det_sel;
  logic       cls_sel;
  logic [1:0] mode;
  logic [1:0] four_pair;
  logic [1:0] dual_sig;
  assign det_sel   = ctrl_q[pcef_pkg::CTRL_DCHG];
  assign cls_sel   = ctrl_q[pcef_pkg::CTRL_CCHG];
  assign mode      = ctrl_q[pcef_pkg::CTRL_MODE +: 2];
  assign four_pair = ctrl_q[pcef_pkg::CTRL_4P +: 2];
  assign dual_sig  = ctrl_q[pcef_pkg::CTRL_DUAL +: 2];

  // ****************************************************************
  // Raw event selection
  // ****************************************************************
  logic [3:0] det_raw;
  logic [3:0] cls_raw;
  // Cycle-occurred or changed-result, per select bit
  assign det_raw = det_sel ? evt.det_chg : evt.det_done;
  assign cls_raw = cls_sel ? evt.cls_chg : evt.cls_done;

  // ****************************************************************
  // Per-port pairing of detection and class events
  // ****************************************************************
  logic [3:0] det_set;
  logic [3:0] cls_set;
  logic [3:0] disc_set;
  logic [15:0] t0_q, t1_q;
  logic [3:0] dpend_q;
  logic [3:0] cpend_q;

  // Each port pairs channels 2p and 2p+1; pending bits hold a result
  // until the partner completes so the host sees one interrupt
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic       fp;
      logic       ds;
      logic       indep;
      logic       dboth;
      logic       cjoin;
      logic [1:0] dhave;
      logic [1:0] chave;
      logic [22:0] dcnt_q;
      logic [22:0] ccnt_q;
      assign fp = four_pair[p];
      assign ds = dual_sig[p];
      // Independent with dual signature, in auto mode or with pending power request
      assign indep = ds & ((mode == pcef_pkg::MODE_AUTO) |
                           (|power_req_pending[2*p +: 2]));
      assign dhave = dpend_q[2*p +: 2] | det_raw[2*p +: 2];
      assign chave = cpend_q[2*p +: 2] | cls_raw[2*p +: 2];
      assign dboth = &dhave;
      // Dual signature, semi-auto, discovery only: join class flags
      assign cjoin = ds & ~indep & (mode == pcef_pkg::MODE_SEMI);

      always_comb begin
        if (!fp || indep) begin
          det_set[2*p +: 2] = det_raw[2*p +: 2];
          cls_set[2*p +: 2] = cls_raw[2*p +: 2];
        end else begin
          det_set[2*p +: 2] = dboth ? 2'b11 : 2'b00;
          if (!ds) begin
            cls_set[2*p +: 2] = cls_raw[2*p +: 2];
          end else if (cjoin) begin
            cls_set[2*p +: 2] = (&chave) ? 2'b11 : 2'b00;
          end else begin
            cls_set[2*p +: 2] = cls_raw[2*p +: 2];
          end
        end
        // Single signature disconnect marks both channels
        if (fp && !ds && |evt.disc[2*p +: 2]) begin
          disc_set[2*p +: 2] = 2'b11;
        end else begin
          disc_set[2*p +: 2] = evt.disc[2*p +: 2];
        end
      end

      // Pending holders; only port 0's detection wait count (low byte) is reported in the status register
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dpend_q[2*p +: 2] <= 2'b00;
          dcnt_q            <= '0;
        end else if (!fp || indep || dboth ||
                     |ch_off[2*p +: 2]) begin
          dpend_q[2*p +: 2] <= 2'b00;
          dcnt_q            <= '0;
        end else if (|dhave) begin
          dpend_q[2*p +: 2] <= dhave;
          dcnt_q            <= dcnt_q + 23'd1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cpend_q[2*p +: 2] <= 2'b00;
          ccnt_q            <= '0;
        end else if (!fp || !cjoin || (&chave) ||
                     |ch_off[2*p +: 2]) begin
          cpend_q[2*p +: 2] <= 2'b00;
          ccnt_q            <= '0;
        end else if (|chave) begin
          cpend_q[2*p +: 2] <= chave;
          ccnt_q            <= ccnt_q + 23'd1;
        end
      end
      assign t0_q[8*p +: 8] = dcnt_q[7:0];
      assign t1_q[8*p +: 8] = ccnt_q[7:0];
    end
  endgenerate

  // ****************************************************************
  // Event registers
  // ****************************************************************
  logic [7:0] det_q;
  logic [7:0] flt_q;
  logic [7:0] stl_q;
  logic [7:0] det_d;
  logic [7:0] flt_d;
  logic [7:0] stl_d;
  logic [7:0] off_mask;
  assign off_mask = {ch_off, ch_off};

  // Next values: the clear or the channel-off mask goes first and new
  // events are ORed in after it, so a set always beats a clear that
  // lands in the same cycle. Detection flags ignore channel-off.
  assign det_d = (clr_det ? 8'h00 : det_q)
                 | {cls_set, det_set};
  // Overload flag comes from the timeout even if cutoff is off;
  // clearing it never touches the engine's timeout counters.
  assign flt_d = ((clr_flt ? 8'h00 : flt_q) & ~off_mask)
                 | {disc_set, evt.ovld};
  assign stl_d = ((clr_stl ? 8'h00 : stl_q) & ~off_mask)
                 | {evt.current_limit_fault, evt.startup_fault};

  // Detection/class flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q <= pcef_pkg::EVT_RST;
    end else begin
      det_q <= det_d;
    end
  end

  // Fault flags: disconnect high nibble, overload-timeout low nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= pcef_pkg::EVT_RST;
    end else begin
      flt_q <= flt_d;
    end
  end

  // Start/limit flags, per channel as each changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stl_q <= pcef_pkg::EVT_RST;
    end else begin
      stl_q <= stl_d;
    end
  end

  // ****************************************************************
  // Summaries and attention pin
  // ****************************************************************
  // Class, detect, overload/limit and disconnect summaries
  assign int_summary = {|det_q[7:4], |det_q[3:0],
                        |(flt_q[3:0] | stl_q[7:4]),
                        |flt_q[7:4]};
  // Pin goes high once all flags are clear, by a clear-on-read of each register holding a set flag or, for fault and start flags, by channel-off
  assign attention_request_n = ~(|{det_q, flt_q, stl_q});

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Captured at the setup edge from the flags' next values, so an event
  // landing on that edge is reported before the access edge clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr[9:2])
        pcef_pkg::DET_VIEW_IDX, pcef_pkg::DET_RC_IDX:
          prdata <= {24'h00_0000, det_d};
        pcef_pkg::FLT_VIEW_IDX, pcef_pkg::FLT_RC_IDX:
          prdata <= {24'h00_0000, flt_d};
        pcef_pkg::STL_VIEW_IDX, pcef_pkg::STL_RC_IDX:
          prdata <= {24'h00_0000, stl_d};
        pcef_pkg::CTRL_IDX: prdata <= {24'h00_0000, ctrl_q};
        pcef_pkg::STAT_IDX: prdata <= {16'h0000, cpend_q, dpend_q, t0_q[7:0]};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Port 0 runs unpaired: dual signature in auto mode or with a power
  // request pending; det_pair_a and semi_join_a skip that case, indep_det_a checks it
  logic indep_any0;
  assign indep_any0 = dual_sig[0] & ((mode == pcef_pkg::MODE_AUTO) |
                                     (|power_req_pending[1:0]));

  // Clear-on-read views empty a register; plain views leave it alone
  single_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_flt && evt.ovld == 4'h0 && evt.disc == 4'h0 |=> flt_q == 8'h00)
    else $error("fault clear-on-read left bits set");
  start_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_stl && evt.current_limit_fault == 4'h0 && evt.startup_fault == 4'h0 |=> stl_q == 8'h00)
    else $error("start clear-on-read left bits set");
  det_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_det && det_set == 4'h0 && cls_set == 4'h0 |=> det_q == 8'h00)
    else $error("detection clear-on-read left bits set");
  event_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_stl && evt.startup_fault[0] && !ch_off[0] |=> stl_q[0])
    else $error("event lost under clear");
  plain_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd && idx == pcef_pkg::FLT_VIEW_IDX && ch_off == 4'h0 |=>
    (flt_q & $past(flt_q)) == $past(flt_q))
    else $error("plain read altered flags");
  attn_pin_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    attention_request_n == ((det_q | flt_q | stl_q) == 8'h00))
    else $error("attention pin disagrees with flags");

  // Each strobe lands in its own bit, one bit per channel
  ovld_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt.ovld[3] |=> flt_q[3])
    else $error("overload strobe not flagged");
  disc_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt.disc[3] |=> flt_q[7])
    else $error("disconnect strobe not flagged");
  current_limit_fault_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt.current_limit_fault[1] |=> stl_q[5])
    else $error("current limit strobe not flagged");
  startup_fault_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    evt.startup_fault[3] |=> stl_q[3])
    else $error("startup fault strobe not flagged");
  chan_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch_off[1] && !evt.ovld[1] |=> !flt_q[1])
    else $error("channel off kept overload flag");
  stl_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch_off[1] && !evt.startup_fault[1] |=> !stl_q[1])
    else $error("channel off kept startup flag");
  det_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !four_pair[1] && !det_sel && evt.det_done[3] |=> det_q[3])
    else $error("detect cycle strobe not flagged");
  cls_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !four_pair[1] && cls_sel && evt.cls_chg[2] |=> det_q[6])
    else $error("class change strobe not flagged");

  // Pairing rules on 4-pair port 0
  ss_disc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    four_pair[0] && !dual_sig[0] && evt.disc[0] |=> flt_q[5:4] == 2'b11)
    else $error("single signature disconnect not on both");
  det_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    four_pair[0] && !indep_any0 && $rose(det_q[0]) |-> det_q[1])
    else $error("4-pair detect flags not together");
  indep_det_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    four_pair[0] && indep_any0 && det_raw[0] |=> det_q[0])
    else $error("independent detect flag held back");
  ss_class_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    four_pair[0] && !dual_sig[0] && cls_raw[0] && !cls_raw[1] &&
    !det_q[5] |=> !det_q[5])
    else $error("single signature class flag on idle pair");
  semi_join_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    four_pair[0] && dual_sig[0] && !indep_any0 &&
    mode == pcef_pkg::MODE_SEMI && cls_set[0] |-> cls_set[1])
    else $error("semi-auto class flags not together");

  clr_read_c: cover property (@(posedge pclk) disable iff (!presetn)
    clr_flt && flt_q != 8'h00);
  pair_join_c: cover property (@(posedge pclk) disable iff (!presetn)
    dpend_q[0] ##[1:50] det_q[1:0] == 2'b11);
  cls_join_c: cover property (@(posedge pclk) disable iff (!presetn)
    cpend_q[2] ##[1:50] det_q[7:6] == 2'b11);
  ss_disc_c: cover property (@(posedge pclk) disable iff (!presetn)
    four_pair[0] && !dual_sig[0] && evt.disc[0]);
  err_resp_c: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);

endmodule

// File: verif/pcef_host_model.sv
// Host model: APB requester issuing event register accesses
`timescale 1ns/1ps
module pcef_host_model (
  // Clock
  input  wire logic        pclk,
  // Request side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // Answer side
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end
  // One transfer, held until pready; bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung = (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: verif/pcef_event_flags_bench.sv
// Bench: views, pairing and clearing of the channel event flags
`timescale 1ns/1ps
module pcef_event_flags_bench;
  // Nets
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic         [11:0] paddr;
  logic         [31:0] pwdata;
  logic         [31:0] prdata;
  logic                pready;
  logic                pslverr;
  pcef_pkg::pcef_evt_s evt;
  logic          [3:0] ch_off;
  logic          [3:0] power_req_pending;
  logic          [3:0] int_summary;
  logic                attention_request_n;
  logic         [31:0] rd;
  logic                err;
  int                  bad_count;
  int                  comparisons;
  // Byte addresses are word index times four
  localparam logic [11:0] A_DV = {2'b00, pcef_pkg::DET_VIEW_IDX, 2'b00};
  localparam logic [11:0] A_DC = {2'b00, pcef_pkg::DET_RC_IDX, 2'b00};
  localparam logic [11:0] A_FV = {2'b00, pcef_pkg::FLT_VIEW_IDX, 2'b00};
  localparam logic [11:0] A_FC = {2'b00, pcef_pkg::FLT_RC_IDX, 2'b00};
  localparam logic [11:0] A_SC = {2'b00, pcef_pkg::STL_RC_IDX, 2'b00};
  localparam logic [11:0] A_CT = {2'b00, pcef_pkg::CTRL_IDX, 2'b00};

  // Clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  pcef_event_flags pcef_event_flags_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .ch_off(ch_off),
    .power_req_pending(power_req_pending), .int_summary(int_summary),
    .attention_request_n(attention_request_n));

  pcef_host_model pcef_host_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    logic hung;
    pcef_host_model_inst.xfer(w, a, wd, rd, err, hung);
    if (hung) begin
      bad_count++;
      stop_test();
    end
  endtask
  // Upper bytes must read zero, so the whole word is compared
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // One-cycle strobe on nibble f of the event bundle
  task automatic pulse(input int f, input logic [3:0] m);
    @(posedge pclk);
    evt <= pcef_pkg::pcef_evt_s'({28'h0, m} << (28 - 4 * f));
    @(posedge pclk);
    evt <= '0;
  endtask
  task automatic clr();
    bus(1'b0, A_DC, 32'h0);
    bus(1'b0, A_FC, 32'h0);
    bus(1'b0, A_SC, 32'h0);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_views();
    logic [11:0] va;
    for (int i = 0; i < 3; i++) begin
      va = A_DV + 12'(8 * i);
      rchk(va, 8'h00);
      pulse(2 + 2 * i, 4'h1);
      pulse(i == 0 ? 0 : 3 + 2 * i, 4'h8);
      rchk(va, 8'h18);
      chk({28'h0, int_summary}, {28'h0, 4'(12'h23c >> (4 * i))});
      chk({31'h0, attention_request_n}, 32'h0);
      rchk(va + 12'h4, 8'h18);
      rchk(va, 8'h00);
      chk({31'h0, attention_request_n}, 32'h1);
    end
  endtask
  // Change-select mode ignores plain cycle strobes
  task automatic t_chg();
    bus(1'b1, A_CT, 32'h3);
    rchk(A_CT, 8'h03);
    pulse(0, 4'h2);
    pulse(2, 4'h2);
    rchk(A_DV, 8'h00);
    pulse(1, 4'h2);
    pulse(3, 4'h4);
    rchk(A_DC, 8'h42);
    bus(1'b1, A_CT, 32'h0);
  endtask
  task automatic t_off();
    for (int f = 4; f < 8; f++) pulse(f, 4'h3);
    @(posedge pclk);
    ch_off <= 4'h2;
    @(posedge pclk);
    ch_off <= 4'h0;
    rchk(A_FV, 8'h11);
    rchk(A_SC, 8'h11);
    clr();
  endtask
  // Overload strobe lands on the very edge of a clearing read
  task automatic t_race();
    pulse(4, 4'h8);
    fork
      bus(1'b0, A_FC, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        evt <= pcef_pkg::pcef_evt_s'(32'h0000_0100);
        @(posedge pclk);
        evt <= '0;
      end
    join
    chk(rd, 32'h80);
    rchk(A_FV, 8'h01);
  endtask
  // Channel 0 then optionally channel 1 of port 0
  task automatic pr(input logic [7:0] c, input logic [3:0] p,
                    input int f, input logic two, input logic [11:0] a,
                    input logic [7:0] e1, input logic [7:0] e2);
    power_req_pending <= p;
    bus(1'b1, A_CT, {24'h0, c});
    pulse(f, 4'h1);
    rchk(a, e1);
    pulse(f, {2'b00, two, 1'b0});
    rchk(a, e2);
    clr();
  endtask
  task automatic t_pair();
    pr(8'h10, 4'h0, 0, 1'b1, A_DV, 8'h00, 8'h03);
    pr(8'h50, 4'h3, 0, 1'b1, A_DV, 8'h01, 8'h03);
    pr(8'h58, 4'h0, 2, 1'b1, A_DV, 8'h10, 8'h30);
    pr(8'h54, 4'h0, 2, 1'b1, A_DV, 8'h00, 8'h30);
    pr(8'h50, 4'h0, 2, 1'b1, A_DV, 8'h10, 8'h30);
    pr(8'h10, 4'h0, 2, 1'b0, A_DV, 8'h10, 8'h10);
    pr(8'h10, 4'h0, 4, 1'b0, A_FV, 8'h30, 8'h30);
    pr(8'h50, 4'h0, 4, 1'b0, A_FV, 8'h10, 8'h10);
    power_req_pending <= 4'h0;
    bus(1'b1, A_CT, 32'h0);
  endtask
  // Refused and ignored accesses leave the flags alone
  task automatic t_err();
    pulse(4, 4'h4);
    bus(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, A_FC + 12'h1, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'b1, A_FV, 32'hff);
    chk({31'h0, err}, 32'h0);
    rchk(A_FV, 8'h40);
  endtask

  // Main sequence
  initial begin
    presetn           = 1'b0;
    evt               = '0;
    ch_off            = 4'h0;
    power_req_pending = 4'h0;
    bad_count         = 0;
    comparisons       = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_views();
    t_chg();
    t_off();
    t_race();
    t_pair();
    t_err();
    stop_test();
  end
endmodule
